// ===== hw/srld_pkg.sv
// Package holding the shared constants of the serial register load path
// What this block does
// - Each word is 24 bits, serial.
// - Low four bits choose destination register.
// - Strobe rising edge copies shift register out.
// - Host shifts MSB first, select last.
// - Bit 0 low selects integer divide register.
// - Bit 0 high: bits 3..1 pick index 0 to 7.
// - Integer divide write restarts lock counters.
// - Host writes integer divide register last.
// - Host may skip eighth register.
package srld_pkg;
    localparam int WORD_W     = 24;  // Programming word width
    localparam int SEL_W      = 4;   // Register select field width
    localparam int NUM_REGS   = 8;   // Destination registers
    localparam int IDX_W      = 3;   // Register index width
    localparam int CLK_DIV    = 4;   // System clocks per link clock half period
    localparam logic [23:0] REG_RESET = 24'h000000;  // Reset value of every stored word
    // Host-side APB register offsets
    localparam logic [7:0] OFS_DATA   = 8'h00;  // Word to send
    localparam logic [7:0] OFS_CTRL   = 8'h04;  // Bit 0 start; write only, reads zero
    localparam logic [7:0] OFS_STATUS = 8'h08;  // Bit 0 busy, bit 1 done sticky
    localparam int CTRL_START_BIT  = 0;  // Start strobe position
    localparam int STAT_BUSY_BIT   = 0;  // Busy flag position
    localparam int STAT_DONE_BIT   = 1;  // Done flag position
    // Decode a received word into a destination index
    function automatic logic [2:0] srld_decode(input logic [3:0] sel);
        if (!sel[0]) begin
            srld_decode = 3'h0;
        end else begin
            srld_decode = sel[3:1];
        end
    endfunction : srld_decode
endpackage : srld_pkg

// ===== hw/srld_if.sv
// Three-wire link joining host and device
interface srld_if;
    logic sclk;     // Serial clock, host driven
    logic sdata;    // Serial data, host driven
    logic latch_strobe;  // Latch strobe, host driven
    modport host (output sclk, output sdata, output latch_strobe);
    modport device (input sclk, input sdata, input latch_strobe);
endinterface : srld_if

// ===== hw/srld_sync.sv
// Two-flop synchroniser with rising edge detect
module srld_sync (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Asynchronous input
    input  wire logic i_async,
    // Synchronised level and rising edge pulse
    output logic      o_level,
    output logic      o_rise
);
    logic meta_reg;  // First stage, read only by second
    logic sync_reg;  // Second stage
    logic last_reg;  // Previous value for edge detect
    // Two stages, then a history flop for edges
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    assign o_level = sync_reg;
    assign o_rise  = sync_reg & ~last_reg;
endmodule : srld_sync

// ===== hw/srld_device.sv
// Device end: shift register, address decode and eight write-only registers
module srld_device (
    // Clock and reset
    input  wire logic                I_CLK,
    input  wire logic                I_RST,
    // Serial link
    srld_if.device                   link,
    // Stored registers, flattened, index 0 in the low word
    output logic [8*24-1:0]          O_REGS,
    // One-cycle pulse restarting lock and fast-lock counters
    output logic                     O_COUNTER_RESTART,
    // One-cycle pulse per latched word, with its index
    output logic                     O_LOAD,
    output logic [2:0]               O_LOAD_INDEX
);
    logic        sclk_rise;    // Link clock rising edge
    logic        data_level;   // Synchronised data
    logic        strobe_rise;  // Latch strobe rising edge
    logic [23:0] shift_reg;    // Incoming bits
    logic [23:0] regs_reg [0:7];  // Stored words
    logic [2:0]  dest;         // Decoded destination
    logic        restart_reg;  // Counter restart pulse
    logic        load_reg;     // Load pulse
    logic [2:0]  load_idx_reg; // Index of last load

    srld_sync u_sync_clk (.i_clk(I_CLK), .i_rst(I_RST), .i_async(link.sclk), .o_level(), .o_rise(sclk_rise));
    srld_sync u_sync_dat (.i_clk(I_CLK), .i_rst(I_RST), .i_async(link.sdata), .o_level(data_level), .o_rise());
    srld_sync u_sync_le (.i_clk(I_CLK), .i_rst(I_RST), .i_async(link.latch_strobe), .o_level(),
                         .o_rise(strobe_rise));

    // Shift on each link clock rise; keeps running so the last 24 bits win
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            shift_reg <= 24'h000000;
        end else if (sclk_rise) begin
            shift_reg <= {shift_reg[22:0], data_level};
        end
    end

    // Select field sits in the low bits because it arrives last
    assign dest = srld_pkg::srld_decode(shift_reg[3:0]);

    // Latch on strobe rise into the decoded register only
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            for (int i = 0; i < srld_pkg::NUM_REGS; i++) begin
                regs_reg[i] <= srld_pkg::REG_RESET;
            end
        end else if (strobe_rise) begin
            regs_reg[dest] <= shift_reg;
        end
    end

    // Pulses for the lock-detect and load observers
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            restart_reg  <= 1'b0;
            load_reg     <= 1'b0;
            load_idx_reg <= 3'h0;
        end else begin
            restart_reg <= strobe_rise & (dest == 3'h0);
            load_reg    <= strobe_rise;
            if (strobe_rise) begin
                load_idx_reg <= dest;
            end
        end
    end

    // Flatten storage; other words untouched by an integer divide write
    always_comb begin
        for (int i = 0; i < srld_pkg::NUM_REGS; i++) begin
            O_REGS[i*24 +: 24] = regs_reg[i];
        end
    end
    assign O_COUNTER_RESTART = restart_reg;
    assign O_LOAD            = load_reg;
    assign O_LOAD_INDEX      = load_idx_reg;
endmodule : srld_device

// ===== hw/srld_host.sv
// Host end: APB slave that serialises 24-bit words onto the three-wire link
module srld_host (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Serial link
    srld_if.host             link
);
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        SRLD_IDLE   = 4'b0001,  // Waiting for start
        SRLD_SHIFT  = 4'b0010,  // Clocking bits out
        SRLD_STROBE = 4'b0100,  // Latch strobe rising
        SRLD_GAP    = 4'b1000   // Strobe held for one half period
    } srld_state_t;

    srld_state_t state_reg;   // Sequencer state
    srld_state_t state_next;  // Next sequencer state
    logic [23:0] data_reg;    // Word written by software
    logic [23:0] sh_reg;      // Outgoing shift register
    logic [4:0]  bit_reg;     // Falling edges still owed
    logic [2:0]  div_reg;     // Half period divider
    logic        sclk_reg;    // Link clock out
    logic        le_reg;      // Latch strobe out
    logic        done_reg;    // Sticky done
    logic        hit_data;    // Access targets the data word
    logic        hit_ctrl;    // Access targets the control word
    logic        hit_status;  // Access targets the status word
    logic        wr;          // APB write access
    logic        start;       // Start request
    logic        half;        // Divider wrap
    logic        div_run;     // Divider enabled
    logic        fall_due;    // Falling link clock edge at this wrap
    logic        word_end;    // Last falling edge of the word
    logic        gap_end;     // Strobe hold finished

    // Address decode, shared by the write paths and the error response
    assign hit_data   = I_PADDR == srld_pkg::OFS_DATA;
    assign hit_ctrl   = I_PADDR == srld_pkg::OFS_CTRL;
    assign hit_status = I_PADDR == srld_pkg::OFS_STATUS;
    // Writes take effect in the access phase; the slave never stalls
    assign wr    = I_PSEL & I_PENABLE & I_PWRITE;
    // A start while busy is dropped without an error
    assign start = wr && hit_ctrl && I_PWDATA[srld_pkg::CTRL_START_BIT] && state_reg == SRLD_IDLE;
    // Divider wraps once per link clock half period
    assign half  = div_reg == 3'(srld_pkg::CLK_DIV - 1);
    // Divider runs while bits go out and while the strobe is held
    assign div_run  = state_reg == SRLD_SHIFT || state_reg == SRLD_GAP;
    // A falling link clock edge is due at this divider wrap
    assign fall_due = state_reg == SRLD_SHIFT && half && sclk_reg;
    // The falling edge after the last bit ends the word
    assign word_end = fall_due && bit_reg == 5'h01;
    // Gap over: strobe drops and the sequencer returns to idle
    assign gap_end  = state_reg == SRLD_GAP && half;

    // Data register; software must write the integer divide word last
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            data_reg <= 24'h000000;
        end else if (wr && hit_data) begin
            // Only the low 24 bits form a programming word
            data_reg <= I_PWDATA[23:0];
        end
    end

    // Divider makes the link clock from the system clock
    always_ff @(posedge I_CLK) begin
        if (I_RST || !div_run) begin
            // Parked at zero so every word starts with a full low phase
            div_reg <= 3'h0;
        end else if (half) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    // Next-state logic: a word runs IDLE, SHIFT, STROBE, GAP and back
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SRLD_IDLE: begin
                // Start is only honoured here, so a start while busy is dropped
                if (start) begin
                    state_next = SRLD_SHIFT;
                end
            end
            SRLD_SHIFT: begin
                // Leave after the falling edge that follows the last bit
                if (word_end) begin
                    state_next = SRLD_STROBE;
                end
            end
            SRLD_STROBE: begin
                // One cycle to raise the strobe with the clock parked low
                state_next = SRLD_GAP;
            end
            SRLD_GAP: begin
                // Strobe held for one divider period before the next word
                if (half) begin
                    state_next = SRLD_IDLE;
                end
            end
            default: begin
                // Illegal code: recover to idle
                state_next = SRLD_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            state_reg <= SRLD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outgoing shift register: loaded on start, moved on each falling link clock
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            sh_reg <= 24'h000000;
        end else if (start) begin
            // Snapshot so a later data write cannot corrupt a word in flight
            sh_reg <= data_reg;
        end else if (fall_due) begin
            // Next bit appears while the clock is low, MSB first
            sh_reg <= {sh_reg[22:0], 1'b0};
        end
    end

    // Bit counter: counts the falling edges still owed for this word
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            bit_reg <= 5'h00;
        end else if (start) begin
            // Loaded with the full word length
            bit_reg <= 5'(srld_pkg::WORD_W);
        end else if (fall_due) begin
            bit_reg <= bit_reg - 5'h01;
        end
    end

    // Link clock: toggles on each divider wrap while shifting, idles low
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            sclk_reg <= 1'b0;
        end else if (state_reg == SRLD_SHIFT && half) begin
            // Rising edge lands mid-bit, so the device samples settled data
            sclk_reg <= ~sclk_reg;
        end
    end

    // Latch strobe: raised with the clock parked, dropped when the gap ends
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            le_reg <= 1'b0;
        end else if (state_reg == SRLD_STROBE) begin
            // Clock already low, so no extra bit can slip in
            le_reg <= 1'b1;
        end else if (gap_end) begin
            le_reg <= 1'b0;
        end
    end

    // Done flag: set wins over a clear in the same cycle
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            done_reg <= 1'b0;
        end else if (gap_end) begin
            // Word fully latched and strobe released
            done_reg <= 1'b1;
        end else if (wr && hit_status && I_PWDATA[srld_pkg::STAT_DONE_BIT]) begin
            // Write one to clear
            done_reg <= 1'b0;
        end
    end

    // Read mux; the control word is write only and reads zero
    always_comb begin
        O_PRDATA = 32'h00000000;
        case (I_PADDR)
            // Pending word as last written
            srld_pkg::OFS_DATA:   O_PRDATA = {8'h00, data_reg};
            // Busy in bit 0, sticky done in bit 1
            srld_pkg::OFS_STATUS: O_PRDATA = {30'h0, done_reg, state_reg != SRLD_IDLE};
            // Unmapped and write-only offsets
            default:              O_PRDATA = 32'h00000000;
        endcase
    end

    // Zero wait states; error only for an unmapped access phase
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !hit_data && !hit_ctrl && !hit_status;
    // Link pins come straight from flip-flops
    assign link.sclk         = sclk_reg;
    assign link.sdata        = sh_reg[23];
    assign link.latch_strobe = le_reg;
endmodule : srld_host

// ===== testbench/srld_link_sva.sv
// Checker for the three-wire link between host and device ends
module srld_link_sva (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // Link wires
    input wire logic sclk,
    input wire logic sdata,
    input wire logic latch_strobe
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    logic [5:0] rise_cnt;  // Link clock rises since the last strobe
    // Count rises; the strobe starts a fresh word
    always_ff @(posedge I_CLK) begin
        if (I_RST || latch_strobe) begin
            rise_cnt <= 6'h00;
        end else if ($rose(sclk)) begin
            rise_cnt <= rise_cnt + 6'h01;
        end
    end
    property p_sclk_high; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("link clock high phase wrong");
    property p_sclk_low; $fell(sclk) |-> !sclk [*4]; endproperty
    a_sclk_low: assert property (p_sclk_low) else $error("link clock low phase short");
    property p_data_hold; $changed(sdata) |-> !sclk; endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
    property p_strobe_width; $rose(latch_strobe) |-> latch_strobe [*4] ##1 !latch_strobe; endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
    property p_strobe_quiet; latch_strobe |-> !sclk; endproperty
    a_strobe_quiet: assert property (p_strobe_quiet) else $error("clock ran during strobe");
    property p_word_len; $rose(latch_strobe) |-> rise_cnt == 6'h18; endproperty
    a_word_len: assert property (p_word_len) else $error("word not 24 bits");
    property p_cnt_max; rise_cnt <= 6'h18; endproperty
    a_cnt_max: assert property (p_cnt_max) else $error("too many bits in a word");
    property p_strobe_follows; ($fell(sclk) && rise_cnt == 6'h18) |-> ##[1:64] $rose(latch_strobe); endproperty
    a_strobe_follows: assert property (p_strobe_follows) else $error("no strobe after word");
    c_strobe: cover property ($rose(latch_strobe));
    c_one_bit: cover property ($rose(sclk) && sdata);
    c_full: cover property (rise_cnt == 6'h18);
endmodule : srld_link_sva

// ===== testbench/testbench.sv
// Self-checking bench joining host and device ends over the link
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk, rst, psel, penable, pwrite, pready, pslverr, restart, load;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata;
    logic [191:0] regs;      // Flattened stored words
    logic [2:0]   load_idx;
    logic [23:0]  exp_regs [8];  // Expected stored words
    int           err_count, n_tests, n_load, n_restart;
    srld_if link ();
    srld_host u_srld_host (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .link(link));
    srld_device u_srld_device (.I_CLK(clk), .I_RST(rst), .link(link), .O_REGS(regs),
        .O_COUNTER_RESTART(restart), .O_LOAD(load), .O_LOAD_INDEX(load_idx));
    srld_link_sva u_srld_link_sva (.I_CLK(clk), .I_RST(rst), .sclk(link.sclk), .sdata(link.sdata),
        .latch_strobe(link.latch_strobe));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Pulses are one cycle wide, so counting edges catches doubles
    always @(posedge clk) begin
        if (load === 1'b1) n_load++;
        if (restart === 1'b1) n_restart++;
    end
    task automatic complete_run;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk32
    task automatic fail_to;
        err_count++;
        $display("BAD %0t wait ran out", $time);
        complete_run();
    endtask : fail_to
    // One APB transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int i;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
            if (i > 20) fail_to();
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // Send one word, then judge decode, load pulse and all stored words
    task automatic send(input logic [23:0] w);
        logic [31:0] q;
        logic        e;
        logic [2:0]  idx;
        int          i, nl, nr;
        nl = n_load;
        nr = n_restart;
        idx = w[0] ? w[3:1] : 3'h0;
        exp_regs[idx] = w;
        apb(1'b1, srld_pkg::OFS_DATA, {8'h00, w}, q, e);
        apb(1'b0, srld_pkg::OFS_DATA, 32'h0, q, e);
        chk32(q, {8'h00, w});
        apb(1'b1, srld_pkg::OFS_STATUS, 32'h00000002, q, e);
        apb(1'b1, srld_pkg::OFS_CTRL, 32'h00000001, q, e);
        i = 0;
        do begin
            apb(1'b0, srld_pkg::OFS_STATUS, 32'h0, q, e);
            i++;
            if (i > 200) fail_to();
        end while (q[srld_pkg::STAT_BUSY_BIT] !== 1'b0);
        chk32({31'h0, q[srld_pkg::STAT_DONE_BIT]}, 32'h1);
        i = 0;
        while (n_load == nl) begin
            @(posedge clk);
            i++;
            if (i > 50) fail_to();
        end
        repeat (2) @(posedge clk);
        chk32(n_load - nl, 1);
        chk32({29'h0, load_idx}, {29'h0, idx});
        chk32(n_restart - nr, (idx == 3'h0) ? 1 : 0);
        for (i = 0; i < 8; i++) chk32({8'h0, regs[i*24+:24]}, {8'h0, exp_regs[i]});
    endtask : send
    // Nine select codes reaching every index, bit 0 low with high upper bits first, plain zero last
    task automatic s_decode;
        logic [3:0] sel [9] = '{4'he, 4'h3, 4'h5, 4'h7, 4'h9, 4'hb, 4'hd, 4'hf, 4'h0};
        for (int k = 0; k < 9; k++) send({k[3:0], 16'h5a3c, sel[k]});
    endtask : s_decode
    // Unmapped access and clearing of the sticky done flag
    task automatic s_status;
        logic [31:0] q;
        logic        e;
        apb(1'b0, 8'h10, 32'h0, q, e);
        chk32({q[30:0], e}, 32'h1);
        apb(1'b1, srld_pkg::OFS_STATUS, 32'h00000002, q, e);
        apb(1'b0, srld_pkg::OFS_STATUS, 32'h0, q, e);
        chk32(q, 32'h0);
    endtask : s_status
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        for (int j = 0; j < 8; j++) exp_regs[j] = srld_pkg::REG_RESET;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk32(regs[31:0], 32'h0);
        s_decode();
        s_status();
        complete_run();
    end
endmodule : testbench
